// *** bench/dmpf_host.sv ***
// Host model: feeds position commands and drives the select pins.
// Assumes its tasks are called by one process at a time.
`timescale 1ns/100ps
module dmpf_host
(
    // Clock
    input wire logic pclk,
    // Command stream
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic signed [31:0] cmd_data,
    // Select pins
    output logic sel_a,
    output logic sel_b
);
    initial
    begin
        {cmd_valid, sel_a, sel_b} = 3'h0;
        cmd_data = 32'h0;
    end
    // Hold one word until taken; ok stays low if the bound ran out
    task automatic send(input logic signed [31:0] v, output logic ok);
        ok = 1'b0;
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_data <= v;
        for (int i = 0; i < 40 && !ok; i++)
        begin
            @(posedge pclk);
            ok = cmd_ready;
        end
        cmd_valid <= 1'b0;
        cmd_data <= ~v; // Stale word never repeats the last one
    endtask
    // Pins move only between motions
    task automatic pins(input logic a, input logic b);
        @(posedge pclk);
        sel_a <= a;
        sel_b <= b;
    endtask
endmodule

// *** bench/dmpf_properties.sv ***
// Port checker for the damping filter select block.
// Assumes pready stays high, so a write lands at psel and penable.
`timescale 1ns/100ps
module dmpf_properties
#(
    parameter int CMD_W = 32
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Streams, pins and slot view
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic signed [CMD_W-1:0] cmd_data,
    input wire logic damping_select_in_a,
    input wire logic damping_select_in_b,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic signed [CMD_W-1:0] out_data,
    input wire logic [3:0] slot_active
);
    logic [3:0] mode_r, mode_nxt;
    logic [1:0] sw_r, sw_nxt, pin_r, pin_nxt, stab_r, stab_nxt;
    logic [2:0] idle_r, idle_nxt;
    logic neg_r, neg_nxt, en;
    logic signed [CMD_W-1:0] last_r, last_nxt;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow settings, pin age and motion sense; ages saturate
    always_comb
    begin
        {sw_nxt, mode_nxt} = {sw_r, mode_r};
        if (psel && penable && pwrite && paddr == 12'h000)
            {sw_nxt, mode_nxt} = {pwdata[9:8], pwdata[3:0]};
        pin_nxt = {damping_select_in_b, damping_select_in_a};
        stab_nxt = (pin_nxt != pin_r) ? 2'h0 : stab_r + {1'b0, stab_r != 2'h3};
        {neg_nxt, last_nxt} = {neg_r, last_r};
        idle_nxt = idle_r + {2'h0, idle_r != 3'h7};
        if (cmd_valid && cmd_ready)
        begin
            neg_nxt = (cmd_data < last_r) || (neg_r && cmd_data == last_r);
            last_nxt = cmd_data;
            idle_nxt = 3'h0;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {mode_r, sw_r, pin_r, stab_r, idle_r, neg_r, last_r} <= '0;
        else
            {mode_r, sw_r, pin_r, stab_r, idle_r, neg_r, last_r} <=
                {mode_nxt, sw_nxt, pin_nxt, stab_nxt, idle_nxt, neg_nxt, last_nxt};
    end
    assign en = mode_r inside {4'h0, 4'h3, 4'h4, 4'h6};
    // Slot choice waits for pins and motion to settle past the synchroniser
    property p_two; $countones(slot_active) <= 2; endproperty
    a_two: assert property (p_two) else $error("too many slots");
    property p_pair; en && sw_r == 2'h0 |-> slot_active == 4'h3; endproperty
    a_pair: assert property (p_pair) else $error("pair slots wrong");
    property p_sel;
        en && sw_r == 2'h1 && stab_r == 2'h3 |-> slot_active == (pin_r[0] ? 4'hA : 4'h5);
    endproperty
    a_sel: assert property (p_sel) else $error("select a slots wrong");
    property p_one;
        en && sw_r == 2'h2 && stab_r == 2'h3 |-> slot_active == 4'h1 << pin_r;
    endproperty
    a_one: assert property (p_one) else $error("single slot wrong");
    property p_dir;
        en && sw_r == 2'h3 && idle_r == 3'h7 |-> slot_active == (neg_r ? 4'hA : 4'h5);
    endproperty
    a_dir: assert property (p_dir) else $error("direction slots wrong");
    property p_en; psel && penable && !pwrite && paddr == 12'h004 |-> prdata[4] == en; endproperty
    a_en: assert property (p_en) else $error("enable view wrong");
    property p_frq;
        psel && penable && !pwrite && paddr[11:4] == 8'h01
        |-> prdata >= 32'h64 && prdata <= 32'h7D0;
    endproperty
    a_frq: assert property (p_frq) else $error("freq out of span");
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
    a_hold: assert property (p_hold) else $error("output dropped");
    c_four: cover property (slot_active == 4'h8);
    c_neg: cover property (sw_r == 2'h3 && neg_r);
    c_full: cover property (!cmd_ready);
endmodule

// *** bench/dmpf_tb.sv ***
// Testbench for the damping filter select block with a host model.
// Assumes the design, host model and checker are compiled first.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
$display("BAD %s exp %0h got %0h", nm, e, g); end end
bind dmpf_top dmpf_properties #(.CMD_W(CMD_W)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
    .damping_select_in_a(damping_select_in_a), .damping_select_in_b(damping_select_in_b),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .slot_active(slot_active));
module testbench
    import dmpf_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ok, chk_on;
    logic cmd_valid, cmd_ready, sel_a, sel_b, out_valid, out_ready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic signed [31:0] cmd_data, out_data, e_w, v;
    logic signed [31:0] dv [4] = '{32'sh100, 32'sh200, 32'sh50, 32'sh60};
    logic [3:0] slot_active;
    logic [1:0] rmode;
    int n_fail, cmp_count, seed, n, i;
    logic signed [31:0] exp_q[$];
    dmpf_top #(.CMD_W(32)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_data(cmd_data), .damping_select_in_a(sel_a), .damping_select_in_b(sel_b),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .slot_active(slot_active));
    dmpf_host host (.pclk(pclk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_data(cmd_data), .sel_a(sel_a), .sel_b(sel_b));
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Far-side stall pattern: low, random or high
    always @(posedge pclk)
        out_ready <= (rmode == 2'h1) ? 1'($random(seed)) : rmode[1];
    // Each word delivered while chk_on is high is matched against the oldest note
    always @(posedge pclk)
    begin
        if (presetn && chk_on && out_valid === 1'b1 && out_ready === 1'b1)
        begin
            e_w = exp_q.size() ? exp_q.pop_front() : ~out_data;
            `CHK("out_data", e_w, out_data)
        end
    end
    // Setup edge, then the access phase is held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        r = prdata;
        {psel, penable} <= 2'h0;
        if (pready !== 1'b1)
        begin
            n_fail++;
            close_out();
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("register", e, r)
        `CHK("pslverr", 1'b0, pslverr)
    endtask
    task automatic push;
        v = $random(seed);
        host.send(v, ok);
        if (ok)
            exp_q.push_back(v);
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (100000) @(posedge pclk);
        n_fail++;
        close_out();
    end
    initial
    begin
        {seed, n_fail, cmp_count} = {32'hEA94, 64'h0};
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {rmode, chk_on, ok} = 4'hB;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("slots", 4'h3, slot_active)
        rdc(12'h000, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            rdc(12'h010 + 12'(4 * i), 32'h64);
            rdc(12'h020 + 12'(4 * i), 32'h0);
        end
        apb(1'b1, 12'h010, 32'h5);
        rdc(12'h010, 32'h64);
        apb(1'b1, 12'h014, 32'hFFF);
        rdc(12'h014, 32'h7D0);
        apb(1'b1, 12'h02C, 32'h20);
        rdc(12'h02C, 32'h20);
        apb(1'b1, 12'h030, 32'h20);
        rdc(12'h030, 32'h0);
        for (i = 0; i < 8; i++)
        begin
            apb(1'b1, 12'h000, 32'(i));
            apb(1'b0, 12'h004, 32'h0);
            `CHK("enable", i inside {0, 3, 4, 6}, r[4])
        end
        $display("settings test done");
        apb(1'b1, 12'h000, 32'h1);
        rmode = 2'h1;
        for (i = 0; i < 12; i++)
            push();
        rmode = 2'h0;
        for (n = 0; ok && n < 20; n++)
            push();
        `CHK("fifo_words", 9, exp_q.size())
        rmode = 2'h2;
        for (i = 0; i < 200 && exp_q.size(); i++)
            @(posedge pclk);
        `CHK("left", 0, exp_q.size())
        $display("pass-through test done");
        apb(1'b1, 12'h000, {22'h0, DMPF_SW_SEL_A, 8'h0});
        for (i = 0; i < 6; i++)
        begin
            if (i == 2)
                apb(1'b1, 12'h000, {22'h0, DMPF_SW_SEL_AB, 8'h0});
            host.pins(i[0], i[1] ^ (i > 1));
            repeat (4) @(posedge pclk);
            `CHK("slots", i < 2 ? 4'h5 << i : 4'h1 << (i - 2), slot_active)
        end
        apb(1'b1, 12'h000, 32'h0);
        @(posedge pclk);
        `CHK("slots", 4'h3, slot_active)
        chk_on = 1'b0;
        apb(1'b1, 12'h000, {22'h0, DMPF_SW_DIR, 8'h0});
        for (i = 0; i < 4; i++)
        begin
            host.send(dv[i], ok);
            repeat (10) @(posedge pclk);
            if (i > 0)
                `CHK("slots", i == 2 ? 4'hA : 4'h5, slot_active)
        end
        // A repeated command at rest passes the active slots unchanged
        chk_on = 1'b1;
        exp_q.push_back(dv[3]);
        host.send(dv[3], ok);
        for (i = 0; i < 200 && exp_q.size(); i++)
            @(posedge pclk);
        `CHK("steady", 0, exp_q.size())
        $display("slot select test done");
        close_out();
    end
endmodule

// *** logic/dmpf_defines.svh ***
// Constants for the damping filter select block: settings, codes, filter scaling.
// Assumes inclusion by the top module only.
// Function
// RULE1: Filtering works only in control modes 0, 3, 4 and 6; otherwise pass-through.
// RULE2: Four filter slots exist; at most two filter the command together.
// RULE3: Active slots remove their chosen vibration frequency from the position command; here each active slot is a first-order follower scaled by its frequency.
// RULE4: Each slot takes its center frequency from its own frequency setting.
// RULE5: Each slot has its own depth setting; zero is the reset value.
// RULE6: Larger depth setting shortens settling, at the cost of more ripple.
// RULE7: Host picks depth so torque never saturates in real operation.
// RULE8: Frequency settings span at least 10.0 to 200.0 Hz.
// RULE9: Mode 0 uses slots 1+2; mode 1 select-a off 1+3, on 2+4.
// RULE10: Mode 2 uses one slot picked by selects b,a: 00=1,01=2,10=3,11=4.
// RULE11: Mode 3 uses slots 1+3 for positive motion, 2+4 for negative.
// RULE12: Host holds select inputs stable while the command moves.
`ifndef DMPF_DEFINES_SVH
`define DMPF_DEFINES_SVH
`define DMPF_MODE_POS 4'h0
`define DMPF_MODE_POS_VEL 4'h3
`define DMPF_MODE_POS_TRQ 4'h4
`define DMPF_MODE_FULL 4'h6
`define DMPF_ADDR_CTRL 12'h000
`define DMPF_ADDR_STAT 12'h004
`define DMPF_ADDR_FREQ0 12'h010
`define DMPF_ADDR_DEPTH0 12'h020
`define DMPF_FREQ_MIN 16'h0064
`define DMPF_FREQ_MAX 16'h07D0
`define DMPF_FREQ_RESET 16'h0064
`define DMPF_DEPTH_RESET 8'h00
`define DMPF_DEPTH_MAX 8'hFF
`define DMPF_UPDATE_HZ 32'd10000
`define DMPF_CLK_HZ 32'd200000000
`define DMPF_UPDATE_CYC (`DMPF_CLK_HZ / `DMPF_UPDATE_HZ)
`endif

// *** logic/dmpf_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module dmpf_fifo
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    // Honest full and empty straight from the count
    assign in_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ;
    assign out_valid = (cnt_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rp_r];

    // Pointer and count next values
    always_comb
    begin
        wp_nxt = push ? ((wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1) : wp_r;
        rp_nxt = pop ? ((rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage has no reset; it is never read while empty
    always_ff @(posedge pclk)
    begin
        if (push)
        begin
            mem[wp_r] <= in_data;
        end
    end
endmodule

// *** logic/dmpf_pkg.sv ***
// Types for the damping filter select block.
// Assumes the defines header is compiled alongside.
package dmpf_pkg;
    typedef enum logic [1:0]
    {
        DMPF_SW_PAIR12 = 2'h0,
        DMPF_SW_SEL_A = 2'h1,
        DMPF_SW_SEL_AB = 2'h2,
        DMPF_SW_DIR = 2'h3
    } dmpf_switch_t;
    typedef logic [3:0] dmpf_slots_t;
endpackage

// *** logic/dmpf_top.sv ***
// Damping filter select: APB settings, slot selection and command-path filtering.
// Assumes a synchronous host command stream and asynchronous select pins.
// Settings reach it over a zero-wait APB port; no interrupt, the host polls status.
// Select pins are synchronised here; commands and APB share pclk.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "dmpf_defines.svh"
module dmpf_top
    import dmpf_pkg::*;
#(
    parameter int CMD_W = 32,
    parameter int FIFO_DEPTH = 8,
    parameter int UPDATE_CYC = `DMPF_UPDATE_CYC
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Position command in (per control period)
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic signed [CMD_W-1:0] cmd_data,
    // Select pins
    input wire logic damping_select_in_a,
    input wire logic damping_select_in_b,
    // Filtered command out
    output logic out_valid,
    input wire logic out_ready,
    output logic signed [CMD_W-1:0] out_data,
    // Active slot view
    output logic [3:0] slot_active
);
    // Settings registers
    logic [3:0] control_mode_setting_r, control_mode_setting_nxt;
    logic [1:0] damping_switch_mode_r, damping_switch_mode_nxt;
    // Slot frequency and depth banks
    logic [15:0] freq_r [4];
    logic [15:0] freq_nxt [4];
    logic [7:0] depth_r [4];
    logic [7:0] depth_nxt [4];
    logic [31:0] prdata_nxt;
    // Select pin synchronisers and direction sense
    logic sa_m_r, sa_r, sb_m_r, sb_r;
    logic sa_m_nxt, sa_nxt, sb_m_nxt, sb_nxt;
    logic dir_neg_r, dir_neg_nxt;
    logic signed [CMD_W-1:0] prev_cmd_r, prev_cmd_nxt;
    // Per-slot filter state and the result stage in front of the FIFO
    logic signed [CMD_W-1:0] state_r [4];
    logic signed [CMD_W-1:0] state_nxt [4];
    logic signed [CMD_W-1:0] res_r, res_nxt;
    logic res_vld_r, res_vld_nxt;
    // Decode and handshake
    dmpf_slots_t sel;
    logic enable;
    logic wr, rd;
    logic fifo_ready;

    // Slot index from a word offset; -1 for anything outside the slot banks
    // Only word-aligned offsets inside a 16-byte bank map to a slot
    function automatic int slot_of(input logic [11:0] a, input logic [11:0] base);
        if (a >= base && a < base + 12'h010 && a[1:0] == 2'h0)
            return int'((a - base) >> 2);
        return -1;
    endfunction

    // Clamp a frequency setting into the usable 10.0 to 200.0 Hz span (0.1 Hz units)
    // Out-of-span values are pulled in rather than refused, so a write never fails
    function automatic logic [15:0] clamp_freq(input logic [15:0] f);
        if (f < `DMPF_FREQ_MIN)
            return `DMPF_FREQ_MIN;
        if (f > `DMPF_FREQ_MAX)
            return `DMPF_FREQ_MAX;
        return f;
    endfunction

    // Zero-wait APB; setup-phase writes never take effect
    // A read latches prdata in setup, so it stands through the access phase
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Settings register next values
    always_comb
    begin
        int s;
        s = 0;
        control_mode_setting_nxt = control_mode_setting_r;
        damping_switch_mode_nxt = damping_switch_mode_r;
        freq_nxt = freq_r;
        depth_nxt = depth_r;
        // Writes land only in the access phase, once per transfer
        if (wr)
        begin
            if (paddr == `DMPF_ADDR_CTRL)
            begin
                control_mode_setting_nxt = pwdata[3:0];
                damping_switch_mode_nxt = pwdata[9:8];
            end
            // Bank offsets outside the four slots are silently ignored
            s = slot_of(paddr, `DMPF_ADDR_FREQ0);
            if (s >= 0)
                freq_nxt[s] = clamp_freq(pwdata[15:0]); // RULE4 RULE8
            s = slot_of(paddr, `DMPF_ADDR_DEPTH0);
            if (s >= 0)
                depth_nxt[s] = pwdata[7:0]; // RULE5
        end
    end

    // Read data, latched in setup; unmapped reads return zero
    always_comb
    begin
        int s;
        s = 0;
        prdata_nxt = prdata;
        // Only a read setup refreshes prdata; otherwise it holds
        if (rd)
        begin
            prdata_nxt = 32'h0000_0000;
            if (paddr == `DMPF_ADDR_CTRL)
                prdata_nxt = {22'h0, damping_switch_mode_r, 4'h0, control_mode_setting_r};
            else if (paddr == `DMPF_ADDR_STAT)
                prdata_nxt = {26'h0, dir_neg_r, enable, slot_active};
            // Later matches win; the banks never overlap the control words
            s = slot_of(paddr, `DMPF_ADDR_FREQ0);
            if (s >= 0)
                prdata_nxt = {16'h0, freq_r[s]};
            s = slot_of(paddr, `DMPF_ADDR_DEPTH0);
            if (s >= 0)
                prdata_nxt = {24'h0, depth_r[s]};
        end
    end

    // Settings and read data; reset gives position mode and pair switching
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_mode_setting_r <= `DMPF_MODE_POS;
            damping_switch_mode_r <= 2'h0;
            prdata <= 32'h0000_0000;
            for (int i = 0; i < 4; i++)
            begin
                freq_r[i] <= `DMPF_FREQ_RESET;
                depth_r[i] <= `DMPF_DEPTH_RESET; // RULE5
            end
        end
        else
        begin
            control_mode_setting_r <= control_mode_setting_nxt;
            damping_switch_mode_r <= damping_switch_mode_nxt;
            prdata <= prdata_nxt;
            freq_r <= freq_nxt;
            depth_r <= depth_nxt;
        end
    end

    // Two-flop synchronisers on the select pins; host keeps them still in motion
    // Next values: only the second stage is read by the slot choice
    always_comb
    begin
        sa_m_nxt = damping_select_in_a;
        sa_nxt = sa_m_r;
        sb_m_nxt = damping_select_in_b;
        sb_nxt = sb_m_r;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sa_m_r <= 1'b0;
            sa_r <= 1'b0;
            sb_m_r <= 1'b0;
            sb_r <= 1'b0;
        end
        else
        begin
            sa_m_r <= sa_m_nxt;
            sa_r <= sa_nxt;
            sb_m_r <= sb_m_nxt;
            sb_r <= sb_nxt; // RULE12
        end
    end

    // Control-mode gate and slot selection
    always_comb
    begin
        // Other control modes pass the command through untouched
        enable = control_mode_setting_r == `DMPF_MODE_POS
            || control_mode_setting_r == `DMPF_MODE_POS_VEL
            || control_mode_setting_r == `DMPF_MODE_POS_TRQ
            || control_mode_setting_r == `DMPF_MODE_FULL; // RULE1
        // Switching mode picks the slots; outside the gate none is shown
        case (dmpf_switch_t'(damping_switch_mode_r))
            DMPF_SW_PAIR12: sel = 4'b0011; // RULE9
            DMPF_SW_SEL_A: sel = sa_r ? 4'b1010 : 4'b0101; // RULE9
            DMPF_SW_SEL_AB: sel = 4'b0001 << {sb_r, sa_r}; // RULE10
            DMPF_SW_DIR: sel = dir_neg_r ? 4'b1010 : 4'b0101; // RULE11
            default: sel = 4'b0000;
        endcase
        slot_active = enable ? sel : 4'b0000; // RULE2
    end

    // Per-slot smoothing stage: a frequency-scaled first-order follower whose
    // step is strengthened by depth, so a higher depth settles faster; each step stays a small
    // fraction of the error, so it never overshoots. Crude next to a true shaper, but cheap and bounded.
    always_comb
    begin
        logic signed [CMD_W-1:0] x;
        logic signed [CMD_W+24:0] diff;
        logic signed [9:0] gain;
        logic signed [CMD_W+24:0] d;
        x = cmd_data;
        diff = '0;
        gain = '0;
        d = '0;
        dir_neg_nxt = dir_neg_r;
        prev_cmd_nxt = prev_cmd_r;
        state_nxt = state_r;
        res_nxt = res_r;
        res_vld_nxt = res_vld_r && !fifo_ready;
        if (cmd_valid && cmd_ready)
        begin
            // An equal command keeps the last direction, so a pause never flips slots
            if (cmd_data != prev_cmd_r)
                dir_neg_nxt = cmd_data < prev_cmd_r; // RULE11
            prev_cmd_nxt = cmd_data;
            for (int i = 0; i < 4; i++)
            begin
                if (slot_active[i])
                begin
                    // Error widened before the subtraction so a large jump cannot wrap
                    diff = (CMD_W+25)'(x) - (CMD_W+25)'(state_r[i]);
                    // Depth maps to a gain of 0x80 to 0xFF, never zero
                    gain = $signed({2'b00, 8'h80 + {1'b0, depth_r[i][7:1]}});
                    d = diff * $signed({1'b0, freq_r[i]}) * gain; // RULE6
                    state_nxt[i] = state_r[i] + CMD_W'(d >>> 24); // RULE3
                    x = state_nxt[i];
                end
                else
                begin
                    // Idle slots follow the raw command so a later switch is bumpless
                    state_nxt[i] = cmd_data;
                end
            end
            // Outside the gate the raw word goes out with the same latency
            res_nxt = enable ? x : cmd_data; // RULE1
            res_vld_nxt = 1'b1;
        end
    end

    // The result stage stalls the input only while its word waits for FIFO room
    assign cmd_ready = !res_vld_r || fifo_ready;

    // Filter state and result stage; reset parks every slot at zero
    // The result stage holds its word until the FIFO takes it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_neg_r <= 1'b0;
            prev_cmd_r <= '0;
            res_r <= '0;
            res_vld_r <= 1'b0;
            for (int i = 0; i < 4; i++)
            begin
                state_r[i] <= '0;
            end
        end
        else
        begin
            dir_neg_r <= dir_neg_nxt;
            prev_cmd_r <= prev_cmd_nxt;
            res_r <= res_nxt;
            res_vld_r <= res_vld_nxt;
            state_r <= state_nxt;
        end
    end

    // Output buffer; back-pressure reaches cmd_ready
    // Its depth sets how long the far side may stall before cmd_ready drops
    dmpf_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(res_vld_r),
        .in_ready(fifo_ready),
        .in_data(res_r),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );
endmodule
